// file: hdl/pllbw_pkg.sv
// pllbw_pkg: constants and types for the loop bandwidth and phase step block
// assumes: shared by the design file and the bench, no import used
package pllbw_pkg;
  localparam int CP_W      = 3;
  localparam int LFR_W     = 5;
  localparam int LFC_W     = 2;
  localparam int SEL_W     = 3;
  localparam int CNT_SET_W = 9;
  localparam int NUM_OUT   = 5;
  localparam int NUM_CNT   = 7;
  localparam int CHAIN_LEN = 144;
  localparam int TAP_W     = 3;
  localparam int BYP_BIT   = 8;
  localparam int STEP_W    = 4;
  localparam logic [STEP_W-1:0] STEP_TIME_DEF = 4'h4;
  localparam logic [SEL_W-1:0] SEL_ALL  = 3'h0;
  localparam logic [SEL_W-1:0] SEL_FB   = 3'h1;
  localparam logic [SEL_W-1:0] SEL_OUT0 = 3'h2;
  localparam logic [SEL_W-1:0] SEL_OUT4 = 3'h6;
  // chain field positions, first bit shifted sits at index 0
  localparam int POS_OUT0 = 0;
  localparam int POS_FB   = 90;
  localparam int POS_PRE  = 108;
  localparam int POS_CP   = 126;
  localparam int POS_LFR  = 135;
  localparam int POS_LFC  = 140;
  localparam int OUT_STRIDE = 18;
  localparam int HI_OFS   = 9;

  typedef struct packed {
    logic [CP_W-1:0]  pump_current_code;
    logic [LFR_W-1:0] loop_resistor_code;
    logic [LFC_W-1:0] loop_capacitor_code;
    logic             code_valid;
  } pllbw_bw_t;

  typedef struct packed {
    logic [SEL_W-1:0] target;
    logic             up;
  } pllbw_step_t;
endpackage

// file: hdl/pllbw_ctrl.sv
// pllbw_ctrl: bandwidth codes, counter bypass and dynamic phase stepping
// assumes: i_scan_clk free running from core logic, i_clk a system clock
// How it works
// - pump current code is 3 bits; only 0, 1, 3, 7 are valid
// - loop resistor code is 5 bits; only the eleven listed values are valid
// - capacitor code is 2 bits; only 0, 1 and 3 are valid
// - pump and filter codes may change while running, bandwidth follows
// - bypassed feedback multiplies by one, other counters divide by one
// - bit 8 of each 9-bit counter setting is bypass and masks the rest
// - bypass bit zero means the counter uses its count fields
// - phase step needs no scan transfer, moves tap of chosen counter
// - each step moves the phase one eighth of the oscillator period
// - output clocks never stop during a phase step
// - target select is registered on a rising scan clock edge
// - select 0 all outputs, 1 feedback, 2 to 6 outputs 0 to 4
// - direction registered on rising edge; 1 up, 0 down
// - each step request produces exactly one step; requests made while a step is in progress are ignored
// - done falls on the edge a step starts, rises when finished
// - request sampled on falling edge, latched two rising edges later
// - codes and counter settings load through a 144-bit scan chain
module pllbw_ctrl #(
  parameter logic [pllbw_pkg::STEP_W-1:0] STEP_TIME = pllbw_pkg::STEP_TIME_DEF
) (
  input  wire logic                                   i_clk,
  input  wire logic                                   i_reset,
  input  wire logic                                   i_scan_clk,
  input  wire logic                                   i_scan_data,
  input  wire logic                                   i_scan_en,
  input  wire logic                                   i_config_update,
  input  wire logic [pllbw_pkg::SEL_W-1:0]            i_phase_sel,
  input  wire logic                                   i_phase_up,
  input  wire logic                                   i_phase_step,
  output logic                                        o_phase_done,
  output logic                                        o_scan_data_out,
  output pllbw_pkg::pllbw_bw_t                        o_bw,
  output logic [pllbw_pkg::NUM_CNT-1:0]               o_bypass,
  output logic [pllbw_pkg::NUM_OUT*pllbw_pkg::TAP_W-1:0] o_out_tap,
  output logic [pllbw_pkg::TAP_W-1:0]                 o_fb_tap,
  output logic                                        o_step_busy
);
  localparam int W = pllbw_pkg::CHAIN_LEN;

  // scan chain, on the link clock
  logic [W-1:0] chain_r;
  logic [W-1:0] cfg_r;
  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      chain_r <= '0;
    end else if (i_scan_en) begin
      chain_r <= {i_scan_data, chain_r[W-1:1]};
    end
  end
  assign o_scan_data_out = chain_r[0];

  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_r <= '0;
    end else if (i_config_update) begin
      cfg_r <= chain_r;
    end
  end

  // phase step sequencer, on the link clock
  typedef enum logic [1:0] {ST_IDLE, ST_LATCH, ST_STEP} pllbw_st_t;
  pllbw_st_t st_r;
  logic step_fall_r;
  logic step_prev_r;
  pllbw_pkg::pllbw_step_t cmd_r;
  logic [pllbw_pkg::STEP_W-1:0] tmr_r;
  logic [pllbw_pkg::NUM_OUT*pllbw_pkg::TAP_W-1:0] out_tap_r;
  logic [pllbw_pkg::TAP_W-1:0] fb_tap_r;
  logic done_r;

  always_ff @(negedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      step_fall_r <= 1'b0;
    end else begin
      step_fall_r <= i_phase_step;
    end
  end

  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      step_prev_r <= 1'b0;
    end else begin
      step_prev_r <= step_fall_r;
    end
  end

  logic step_edge;
  assign step_edge = step_fall_r && !step_prev_r;

  // request seen on the first rising edge, latched on the second
  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (step_edge && done_r) begin
            st_r <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          st_r <= ST_STEP;
        end
        ST_STEP: begin
          if (tmr_r == '0) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // target and direction, taken on the edge where done falls
  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      cmd_r <= '0;
    end else if (st_r == ST_LATCH) begin
      cmd_r <= '{target: i_phase_sel, up: i_phase_up};
    end
  end

  // step time, loaded with the command and run down to zero
  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      tmr_r <= '0;
    end else if (st_r == ST_LATCH) begin
      tmr_r <= STEP_TIME;
    end else if (st_r == ST_STEP && tmr_r != '0) begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  // done: falls on the latch edge, rises after the internal step time
  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      done_r <= 1'b1;
    end else if (st_r == ST_LATCH) begin
      done_r <= 1'b0;
    end else if (st_r == ST_STEP && tmr_r == '0) begin
      done_r <= 1'b1;
    end
  end
  assign o_phase_done = done_r;

  // one tap is one eighth of the oscillator period; wraps around
  function automatic logic [pllbw_pkg::TAP_W-1:0] tap_move(
    input logic [pllbw_pkg::TAP_W-1:0] t,
    input logic                        up
  );
    tap_move = up ? t + 1'b1 : t - 1'b1;
  endfunction

  logic apply;
  assign apply = (st_r == ST_STEP) && (tmr_r == STEP_TIME);

  genvar g;
  generate
    for (g = 0; g < pllbw_pkg::NUM_OUT; g++) begin : g_out
      localparam logic [pllbw_pkg::SEL_W-1:0] MY_SEL =
        pllbw_pkg::SEL_W'(pllbw_pkg::SEL_OUT0 + g);
      always_ff @(posedge i_scan_clk or posedge i_reset) begin
        if (i_reset) begin
          out_tap_r[g*pllbw_pkg::TAP_W +: pllbw_pkg::TAP_W] <= '0;
        end else if (apply && (cmd_r.target == pllbw_pkg::SEL_ALL ||
                               cmd_r.target == MY_SEL)) begin
          out_tap_r[g*pllbw_pkg::TAP_W +: pllbw_pkg::TAP_W] <=
            tap_move(out_tap_r[g*pllbw_pkg::TAP_W +: pllbw_pkg::TAP_W],
                     cmd_r.up);
        end
      end
    end
  endgenerate

  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      fb_tap_r <= '0;
    end else if (apply && cmd_r.target == pllbw_pkg::SEL_FB) begin
      fb_tap_r <= tap_move(fb_tap_r, cmd_r.up);
    end
  end

  // outputs keep running: only the tap index changes, no gating
  assign o_out_tap = out_tap_r;
  assign o_fb_tap  = fb_tap_r;

  // bandwidth codes and validity, decoded in link domain
  logic [pllbw_pkg::CP_W-1:0]  cp_c;
  logic [pllbw_pkg::LFR_W-1:0] lfr_c;
  logic [pllbw_pkg::LFC_W-1:0] lfc_c;
  logic cp_ok;
  logic lfr_ok;
  logic lfc_ok;
  assign cp_c  = cfg_r[pllbw_pkg::POS_CP  +: pllbw_pkg::CP_W];
  assign lfr_c = cfg_r[pllbw_pkg::POS_LFR +: pllbw_pkg::LFR_W];
  assign lfc_c = cfg_r[pllbw_pkg::POS_LFC +: pllbw_pkg::LFC_W];
  assign cp_ok = (cp_c == 3'h0) || (cp_c == 3'h1) ||
                 (cp_c == 3'h3) || (cp_c == 3'h7);
  always_comb begin
    case (lfr_c)
      5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13,
      5'h14, 5'h18, 5'h1b, 5'h1c, 5'h1e: lfr_ok = 1'b1;
      default: lfr_ok = 1'b0;
    endcase
  end
  assign lfc_ok = (lfc_c != 2'h2);

  // bypass: msb of each counter setting masks its count fields
  logic [pllbw_pkg::NUM_CNT-1:0] byp_c;
  generate
    for (g = 0; g < pllbw_pkg::NUM_CNT; g++) begin : g_byp
      assign byp_c[g] = cfg_r[pllbw_pkg::POS_OUT0 + g*pllbw_pkg::OUT_STRIDE
                              + pllbw_pkg::BYP_BIT];
    end
  endgenerate

  // system domain view: codes cross by a toggle handshake; the held
  // word stays put while its toggle passes two flops
  localparam int SW = pllbw_pkg::CP_W + pllbw_pkg::LFR_W + pllbw_pkg::LFC_W
                      + 1 + pllbw_pkg::NUM_CNT;
  localparam int BW = SW - pllbw_pkg::NUM_CNT;
  logic          upd_d_r;
  logic          upd_d2_r;
  logic          xfer_go;
  logic [SW-1:0] xfer_r;
  logic          xfer_tgl_r;
  logic          tgl_s1_r;
  logic          tgl_s2_r;
  logic          tgl_s3_r;
  logic [SW-1:0] sys_word_r;
  logic          busy_s1_r;
  logic          busy_s2_r;

  // one link cycle after the update, so cfg_r has already settled
  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      upd_d_r  <= 1'b0;
      upd_d2_r <= 1'b0;
    end else begin
      upd_d_r  <= i_config_update;
      upd_d2_r <= upd_d_r;
    end
  end

  assign xfer_go = upd_d_r && !upd_d2_r;

  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      xfer_r <= '0;
    end else if (xfer_go) begin
      xfer_r <= {cp_c, lfr_c, lfc_c, cp_ok && lfr_ok && lfc_ok, byp_c};
    end
  end

  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      xfer_tgl_r <= 1'b0;
    end else if (xfer_go) begin
      xfer_tgl_r <= !xfer_tgl_r;
    end
  end

  // toggle into the system clock, third flop for its edge
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= xfer_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  // held word is long stable once the toggle edge shows here
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sys_word_r <= '0;
    end else if (tgl_s2_r != tgl_s3_r) begin
      sys_word_r <= xfer_r;
    end
  end

  // busy is a single bit, two flops suffice
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
    end else begin
      busy_s1_r <= !done_r;
      busy_s2_r <= busy_s1_r;
    end
  end

  assign o_bw        = sys_word_r[SW-1 -: BW];
  assign o_bypass    = sys_word_r[pllbw_pkg::NUM_CNT-1:0];
  assign o_step_busy = busy_s2_r;
endmodule

// file: test/pllbw_props.sv
// checker: phase step timing seen at the block ports
// assumes: bound onto pllbw_ctrl, scan clock domain only
module pllbw_props #(
  parameter logic [3:0] STEP_TIME = 4'h4
) (
  input wire logic        i_reset,
  input wire logic        i_scan_clk,
  input wire logic [2:0]  i_phase_sel,
  input wire logic        i_phase_up,
  input wire logic        i_phase_step,
  input wire logic        o_phase_done,
  input wire logic [14:0] o_out_tap,
  input wire logic [2:0]  o_fb_tap
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_scan_clk);
  endclocking
  default disable iff (i_reset);
  logic [4:0]  low_r;
  logic [14:0] tap_r;
  always_ff @(posedge i_scan_clk or posedge i_reset) begin
    if (i_reset) begin
      low_r <= '0;
      tap_r <= '0;
    end else begin
      low_r <= o_phase_done ? 5'h0 : low_r + 5'h1;
      tap_r <= o_out_tap;
    end
  end
  sequence go_s(logic [2:0] s, logic u);
    $fell(o_phase_done) ##0 (i_phase_sel == s && i_phase_up == u);
  endsequence
  req_held_a: assert property ($fell(o_phase_done) |->
    $past(i_phase_step) && $past(i_phase_step, 2)) else $error("bad launch");
  fb_up_a: assert property (go_s(3'h1, 1'b1) |=>
    o_fb_tap == $past(o_fb_tap) + 3'h1) else $error("fb not up");
  fb_down_a: assert property (go_s(3'h1, 1'b0) |=>
    o_fb_tap == $past(o_fb_tap) - 3'h1) else $error("fb not down");
  out0_up_a: assert property (go_s(3'h2, 1'b1) |=>
    o_out_tap[2:0] == tap_r[2:0] + 3'h1 && $stable(o_fb_tap))
    else $error("out0 not up");
  out4_down_a: assert property (go_s(3'h6, 1'b0) |=>
    o_out_tap[14:12] == tap_r[14:12] - 3'h1 && o_out_tap[11:0] == tap_r[11:0])
    else $error("out4 not down");
  all_up_a: assert property (go_s(3'h0, 1'b1) |=>
    o_out_tap[14:12] == tap_r[14:12] + 3'h1 && $stable(o_fb_tap))
    else $error("all not up");
  done_len_a: assert property ($rose(o_phase_done) |->
    low_r == STEP_TIME + 1) else $error("done low time wrong");
  one_step_a: assert property (
    $changed(o_fb_tap) || $changed(o_out_tap) |->
    !$past(o_phase_done) && $past(o_phase_done, 2)) else $error("stray step");
  no_retrig_a: assert property (
    $rose(o_phase_done) && i_phase_step |-> o_phase_done[*3])
    else $error("held request restarted");
endmodule
bind pllbw_ctrl pllbw_props #(.STEP_TIME(STEP_TIME)) props_u (
  .i_reset(i_reset), .i_scan_clk(i_scan_clk), .i_phase_sel(i_phase_sel),
  .i_phase_up(i_phase_up), .i_phase_step(i_phase_step),
  .o_phase_done(o_phase_done), .o_out_tap(o_out_tap), .o_fb_tap(o_fb_tap));

// file: test/pllbw_core_model.sv
// partner: core logic making scan clock, chain loads and phase steps
// assumes: the bench calls its tasks; o_hang reports a stuck wait
module pllbw_core_model (
  output logic       o_scan_clk = 1'b0,
  output logic       o_scan_data = 1'b0,
  output logic       o_scan_en = 1'b0,
  output logic       o_config_update = 1'b0,
  output logic [2:0] o_phase_sel = 3'h0,
  output logic       o_phase_up = 1'b0,
  output logic       o_phase_step = 1'b0,
  output logic       o_hang = 1'b0,
  input  wire logic  i_phase_done
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    #3.1;
    forever #7.5 o_scan_clk = ~o_scan_clk;
  end
  task automatic wait_done(input logic v);
    int n;
    n = 0;
    while (i_phase_done !== v && n < 40) begin
      @(negedge o_scan_clk);
      n++;
    end
    if (i_phase_done !== v) o_hang = 1'b1;
  endtask
  // mode 1 re-pulses while busy, mode 2 holds the request past done
  task automatic do_step(input logic [2:0] s, input logic u, input int m);
    @(posedge o_scan_clk);
    o_phase_sel <= s;
    o_phase_up <= u;
    o_phase_step <= 1'b1;
    wait_done(1'b0);
    if (m != 2) begin
      @(posedge o_scan_clk);
      o_phase_step <= 1'b0;
    end
    if (m == 1) begin
      repeat (2) @(posedge o_scan_clk);
      o_phase_step <= 1'b1;
      repeat (2) @(posedge o_scan_clk);
      o_phase_step <= 1'b0;
    end
    wait_done(1'b1);
    repeat (4) @(posedge o_scan_clk);
    o_phase_step <= 1'b0;
  endtask
  task automatic load_chain(input logic [143:0] v);
    @(posedge o_scan_clk);
    o_scan_en <= 1'b1;
    for (int i = 0; i < 144; i++) begin
      o_scan_data <= v[i];
      @(posedge o_scan_clk);
    end
    o_scan_en <= 1'b0;
    o_scan_data <= ~v[143];
    o_config_update <= 1'b1;
    @(posedge o_scan_clk);
    o_config_update <= 1'b0;
  endtask
endmodule

// file: test/tb_top.sv
// bench: chain loads and phase steps, results checked through queues
// assumes: design, checker and core model compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sck, sdat, sen, upd, up, step, done, hang, sdo, bsy;
  logic [2:0] sel, fb;
  logic [14:0] outt;
  logic [6:0] byp;
  pllbw_pkg::pllbw_bw_t bw;
  logic [19:0] tq[$], cq[$];
  int error_cnt, checks_done, bsy_cnt;
  event cfg_ev;
  always #25 clk = ~clk;
  pllbw_ctrl dut_u (.i_clk(clk), .i_reset(rst), .i_scan_clk(sck),
    .i_scan_data(sdat), .i_scan_en(sen), .i_config_update(upd),
    .i_phase_sel(sel), .i_phase_up(up), .i_phase_step(step),
    .o_phase_done(done), .o_scan_data_out(sdo), .o_bw(bw), .o_bypass(byp),
    .o_out_tap(outt), .o_fb_tap(fb), .o_step_busy(bsy));
  pllbw_core_model core_u (.o_scan_clk(sck), .o_scan_data(sdat),
    .o_scan_en(sen), .o_config_update(upd), .o_phase_sel(sel),
    .o_phase_up(up), .o_phase_step(step), .o_hang(hang),
    .i_phase_done(done));
  task automatic cmp(input string n, input logic [19:0] e, g);
    checks_done++;
    if (e !== g) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge done) if (!rst)
    cmp("taps", tq.size() ? tq.pop_front() : 20'hx,
        {2'b00, fb, outt});
  always @(cfg_ev) cmp("cfg", cq.pop_front(), {bw, byp, sdo, bsy});
  always @(posedge bsy) bsy_cnt++;
  always @(posedge hang) begin
    error_cnt++;
    give_verdict;
  end
  initial begin
    int cpl[4] = '{0, 1, 3, 7};
    int rl[11] = '{0, 3, 4, 8, 16, 19, 20, 24, 27, 28, 30};
    logic [143:0] v;
    logic [17:0] mt;
    logic [2:0] s;
    logic u;
    mt = '0;
    void'($urandom(7004));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 13; i++) begin
      v = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
      if (i < 11) v[pllbw_pkg::POS_CP +: 3] = 3'(cpl[i % 4]);
      if (i < 11) v[pllbw_pkg::POS_LFR +: 5] = 5'(rl[i]);
      if (i < 11) v[pllbw_pkg::POS_LFC +: 2] = 2'(i % 3 == 2 ? 3 : i % 3);
      core_u.load_chain(v);
      cq.push_back({v[128:126], v[139:135], v[141:140], 1'b0, v[116], v[98],
                    v[80], v[62], v[44], v[26], v[8], v[0], 1'b0});
      cq[$][9] = (v[128:126] inside {0, 1, 3, 7}) && (v[141:140] != 2)
        && (int'(v[139:135]) inside {0, 3, 4, 8, 16, 19, 20, 24, 27, 28, 30});
      repeat (6) @(negedge clk);
      -> cfg_ev;
    end
    for (int i = 0; i < 24; i++) begin
      s = (i < 14) ? 3'(i % 7) : 3'($urandom_range(6));
      u = (i < 7) || (i >= 14 && $urandom_range(1) == 1);
      for (int k = 0; k < 6; k++)
        if ((s == 0 && k < 5) || (s == 1 && k == 5) || s == k + 2)
          mt[k*3 +: 3] = u ? mt[k*3 +: 3] + 3'h1 : mt[k*3 +: 3] - 3'h1;
      tq.push_back({2'b00, mt});
      core_u.do_step(s, u, (i % 5 > 2) ? i % 5 - 2 : 0);
    end
    cmp("left", 20'h0, 20'(tq.size() + cq.size()));
    cmp("busy", 20'h18, 20'(bsy_cnt));
    give_verdict;
  end
endmodule
